// file: verilog/csm_register_map.sv
// Serial-port register map of a converter with shadowed function registers.
// Assumes sclk, csb and sdio are asynchronous pins much slower than core_clk.
`timescale 1ns/1ps
`default_nettype none
module csm_register_map #(
    parameter logic [7:0] IDENTITY_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] GRADE_CODE = 8'h00
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Serial port pins
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    // Port configuration state
    output logic lsb_first,
    output logic soft_reset,
    // Active function registers, entry 0 at address 0x08
    output logic [csm_pkg::CSM_FUNC_COUNT*csm_pkg::CSM_REG_BITS-1:0] func_active
);
    import csm_pkg::*;

    logic [CSM_PIN_COUNT-1:0] pin_raw;
    logic [CSM_PIN_COUNT-1:0] pin_s1_q;
    logic [CSM_PIN_COUNT-1:0] pin_s2_q;
    logic [CSM_PIN_COUNT-1:0] pin_s3_q;
    logic [CSM_PIN_COUNT-1:0] pin_f_q;
    logic [CSM_PIN_COUNT-1:0] pin_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic in_frame;

    csm_phase_type phase_q;
    logic [4:0] bit_cnt_q;
    logic [CSM_INSTR_BITS-1:0] instr_sh_q;
    logic [7:0] data_sh_q;
    logic [CSM_INSTR_BITS-1:0] instr_word;
    logic [7:0] data_byte;
    logic is_read_q;
    logic stream_q;
    logic [1:0] bytes_left_q;
    logic [CSM_ADDR_BITS-1:0] addr_q;
    logic [CSM_ADDR_BITS-1:0] addr_next;
    logic [CSM_ADDR_BITS-1:0] addr_step;

    logic wr_en;
    logic [7:0] wr_addr;
    logic rd_en;
    logic [CSM_ADDR_BITS-1:0] rd_addr;
    logic rd_pend_q;
    logic [CSM_ADDR_BITS-1:0] rd_addr_q;
    logic [7:0] bank_rd_data;
    logic [7:0] local_rd;
    logic [7:0] tx_q;

    logic commit_q;
    logic lsb_first_q;
    logic soft_reset_q;
    logic sdio_out_q;
    logic sdio_oe_q;
    logic first_q;

    assign pin_raw = {sclk, csb, sdio_in};

    // Three synchroniser flops per pin; a level is accepted once the last two agree
    for (genvar p = 0; p < CSM_PIN_COUNT; p++) begin : g_pin
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                pin_s1_q[p] <= CSM_PIN_IDLE[p];
                pin_s2_q[p] <= CSM_PIN_IDLE[p];
                pin_s3_q[p] <= CSM_PIN_IDLE[p];
                pin_f_q[p] <= CSM_PIN_IDLE[p];
                pin_prev_q[p] <= CSM_PIN_IDLE[p];
            end else begin
                pin_s1_q[p] <= pin_raw[p];
                pin_s2_q[p] <= pin_s1_q[p];
                pin_s3_q[p] <= pin_s2_q[p];
                if (pin_s2_q[p] == pin_s3_q[p]) begin
                    pin_f_q[p] <= pin_s3_q[p];
                end
                pin_prev_q[p] <= pin_f_q[p];
            end
        end
    end

    assign in_frame = !pin_f_q[CSM_PIN_CSB];
    assign sclk_rise = in_frame && pin_f_q[CSM_PIN_SCLK] && !pin_prev_q[CSM_PIN_SCLK];
    assign sclk_fall = in_frame && !pin_f_q[CSM_PIN_SCLK] && pin_prev_q[CSM_PIN_SCLK];

    // Shift order follows the port configuration; LSB-first fills from the top
    always_comb begin
        if (lsb_first_q) begin
            instr_word = {pin_f_q[CSM_PIN_SDIO], instr_sh_q[CSM_INSTR_BITS-1:1]};
            data_byte = {pin_f_q[CSM_PIN_SDIO], data_sh_q[7:1]};
            addr_step = addr_q + 13'h0001;
        end else begin
            instr_word = {instr_sh_q[CSM_INSTR_BITS-2:0], pin_f_q[CSM_PIN_SDIO]};
            data_byte = {data_sh_q[6:0], pin_f_q[CSM_PIN_SDIO]};
            addr_step = addr_q - 13'h0001;
        end
    end

    assign addr_next = instr_word[CSM_ADDR_BITS-1:0];
    assign wr_en = sclk_rise && phase_q == CSM_PH_DATA && bit_cnt_q == 5'h07 && !is_read_q
        && addr_q[CSM_ADDR_BITS-1:8] == 5'h00;
    assign wr_addr = addr_q[7:0];
    // Next byte is fetched as the previous one completes, ready for the next falling edge
    // A process, not an assign, so that state read inside the function wakes it
    always_comb begin
        rd_en = sclk_rise && is_read_q_next();
    end
    assign rd_addr = (phase_q == CSM_PH_INSTR) ? addr_next : addr_step;

    function automatic logic is_read_q_next();
        if (phase_q == CSM_PH_INSTR) begin
            return bit_cnt_q == 5'h0f && instr_word[CSM_INSTR_RW];
        end
        return phase_q == CSM_PH_DATA && bit_cnt_q == 5'h07 && is_read_q && (stream_q || bytes_left_q != 2'h0);
    endfunction

    // Frame sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= CSM_PH_IDLE;
            bit_cnt_q <= 5'h00;
            instr_sh_q <= 16'h0000;
            data_sh_q <= 8'h00;
            is_read_q <= 1'b0;
            stream_q <= 1'b0;
            bytes_left_q <= 2'h0;
            addr_q <= 13'h0000;
        end else if (!in_frame) begin
            phase_q <= CSM_PH_IDLE;
            bit_cnt_q <= 5'h00;
        end else if (phase_q == CSM_PH_IDLE) begin
            phase_q <= CSM_PH_INSTR;
        end else if (sclk_rise) begin
            unique case (phase_q)
                CSM_PH_INSTR: begin
                    instr_sh_q <= instr_word;
                    if (bit_cnt_q == 5'h0f) begin
                        phase_q <= CSM_PH_DATA;
                        bit_cnt_q <= 5'h00;
                        is_read_q <= instr_word[CSM_INSTR_RW];
                        stream_q <= instr_word[CSM_INSTR_LEN_HI:CSM_INSTR_LEN_LO] == CSM_LEN_STREAM;
                        bytes_left_q <= instr_word[CSM_INSTR_LEN_HI:CSM_INSTR_LEN_LO];
                        addr_q <= addr_next;
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                end
                CSM_PH_DATA: begin
                    data_sh_q <= data_byte;
                    if (bit_cnt_q == 5'h07) begin
                        bit_cnt_q <= 5'h00;
                        addr_q <= addr_step;
                        if (!stream_q) begin
                            if (bytes_left_q == 2'h0) begin
                                phase_q <= CSM_PH_DONE;
                            end else begin
                                bytes_left_q <= bytes_left_q - 2'h1;
                            end
                        end
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                end
                CSM_PH_DONE: begin
                    bit_cnt_q <= 5'h00;
                end
                CSM_PH_IDLE: begin
                    bit_cnt_q <= 5'h00;
                end
            endcase
        end
    end

    // Commit pulse lasts one cycle, so the bit clears by itself
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            commit_q <= 1'b0;
        end else begin
            commit_q <= wr_en && wr_addr == CSM_ADDR_COMMIT && data_byte[CSM_COMMIT_BIT];
        end
    end

    // Either mirrored copy of a field sets it, so both shift orders work
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lsb_first_q <= CSM_RST_PORT_CFG[CSM_CFG_LSB_HI];
            soft_reset_q <= CSM_RST_PORT_CFG[CSM_CFG_SRST_HI];
        end else if (wr_en && wr_addr == CSM_ADDR_PORT_CFG) begin
            lsb_first_q <= data_byte[CSM_CFG_LSB_HI] | data_byte[CSM_CFG_LSB_LO];
            soft_reset_q <= data_byte[CSM_CFG_SRST_HI] | data_byte[CSM_CFG_SRST_LO];
        end
    end

    // Local registers; identity and grade have no storage, so writes to them vanish
    always_comb begin
        local_rd = CSM_RST_DATA;
        if (rd_addr_q[CSM_ADDR_BITS-1:8] != 5'h00) begin
            local_rd = CSM_RST_DATA;
        end else if (rd_addr_q[7:0] == CSM_ADDR_PORT_CFG) begin
            local_rd = CSM_RST_PORT_CFG;
            local_rd[CSM_CFG_LSB_HI] = lsb_first_q;
            local_rd[CSM_CFG_LSB_LO] = lsb_first_q;
            local_rd[CSM_CFG_SRST_HI] = soft_reset_q;
            local_rd[CSM_CFG_SRST_LO] = soft_reset_q;
        end else if (rd_addr_q[7:0] == CSM_ADDR_IDENTITY) begin
            local_rd = IDENTITY_CODE;
        end else if (rd_addr_q[7:0] == CSM_ADDR_GRADE) begin
            local_rd = GRADE_CODE;
        end else if (rd_addr_q[7:0] == CSM_ADDR_COMMIT) begin
            local_rd[CSM_COMMIT_BIT] = commit_q;
        end else if (rd_addr_q[7:0] >= CSM_ADDR_FUNC_FIRST && rd_addr_q[7:0] <= CSM_ADDR_FUNC_LAST) begin
            local_rd = bank_rd_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 13'h0000;
            tx_q <= CSM_RST_DATA;
        end else begin
            rd_pend_q <= rd_en;
            if (rd_en) begin
                rd_addr_q <= rd_addr;
            end
            if (rd_pend_q) begin
                tx_q <= local_rd;
            end else if (sclk_fall && phase_q == CSM_PH_DATA && is_read_q) begin
                tx_q <= lsb_first_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
            end
        end
    end

    // Read data changes on falling sclk so the host samples it on the rising edge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sdio_out_q <= 1'b0;
            sdio_oe_q <= 1'b0;
        end else if (!in_frame) begin
            sdio_oe_q <= 1'b0;
        end else if (sclk_fall && phase_q == CSM_PH_DATA && is_read_q) begin
            sdio_out_q <= lsb_first_q ? tx_q[0] : tx_q[7];
            sdio_oe_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    csm_reg_bank u_bank (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_en(wr_en && !(wr_addr < CSM_ADDR_FUNC_FIRST)),
        .wr_addr(wr_addr),
        .wr_data(data_byte),
        .rd_en(rd_en),
        .rd_addr(rd_addr[7:0]),
        .rd_data(bank_rd_data),
        .commit(commit_q),
        .active_flat(func_active)
    );

    assign sdio_out = sdio_out_q;
    assign sdio_oe = sdio_oe_q;
    assign lsb_first = lsb_first_q;
    assign soft_reset = soft_reset_q;

    a_commit_autoclr: assert property (@(posedge core_clk) disable iff (!resetn)
        commit_q |=> !commit_q)
        else $error("commit bit did not clear");
    a_commit_cause: assert property (@(posedge core_clk) disable iff (!resetn)
        commit_q |-> $past(wr_en && wr_addr == CSM_ADDR_COMMIT && data_byte[CSM_COMMIT_BIT]))
        else $error("commit without write of one to commit address");
    a_cfg_mirror: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_pend_q && rd_addr_q == 13'h0000 |=> tx_q[CSM_CFG_ONE_HI:CSM_CFG_ONE_LO] == 2'b11
            && tx_q[CSM_CFG_LSB_HI] == tx_q[CSM_CFG_LSB_LO] && tx_q[CSM_CFG_SRST_HI] == tx_q[CSM_CFG_SRST_LO]
            && tx_q[7] == 1'b0 && tx_q[0] == 1'b0)
        else $error("port configuration readback not mirrored");
    a_id_readback: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_pend_q && rd_addr_q == 13'h0001 |=> tx_q == IDENTITY_CODE)
        else $error("identity readback wrong");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_pend_q && (rd_addr_q > 13'h0025 && rd_addr_q != 13'h00ff || rd_addr_q inside {[13'h0003:13'h0007]})
            |=> tx_q == 8'h00)
        else $error("unmapped address read nonzero");
    a_fmt_default: assert property (@(posedge core_clk) disable iff (!resetn)
        first_q |-> func_active[(CSM_ADDR_OUT_FMT-CSM_ADDR_FUNC_FIRST)*CSM_REG_BITS +: CSM_REG_BITS] == 8'h01)
        else $error("output format default wrong");
    a_cfg_default: assert property (@(posedge core_clk) disable iff (!resetn)
        first_q |-> !lsb_first_q && !soft_reset_q)
        else $error("port configuration default wrong");
    a_msb_order: assert property (@(posedge core_clk) disable iff (!resetn)
        sclk_fall && phase_q == CSM_PH_DATA && is_read_q && !lsb_first_q && !rd_pend_q
            |=> sdio_out_q == $past(tx_q[7]) && sdio_oe_q)
        else $error("read bit not sent most significant first");

endmodule
`default_nettype wire

// file: verilog/csm_pkg.sv
// Constants and types of the shadowed converter register map.
// Assumes 8-bit registers behind a 3-wire serial port with 16-bit instructions.
package csm_pkg;

    // Register addresses
    localparam logic [7:0] CSM_ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] CSM_ADDR_IDENTITY = 8'h01;
    localparam logic [7:0] CSM_ADDR_GRADE = 8'h02;
    localparam logic [7:0] CSM_ADDR_COMMIT = 8'hff;
    localparam logic [7:0] CSM_ADDR_FUNC_FIRST = 8'h08;
    localparam logic [7:0] CSM_ADDR_CLOCK = 8'h09;
    localparam logic [7:0] CSM_ADDR_OUT_FMT = 8'h14;
    localparam logic [7:0] CSM_ADDR_SHADOW_LAST = 8'h20;
    localparam logic [7:0] CSM_ADDR_FUNC_LAST = 8'h25;
    localparam int CSM_FUNC_COUNT = 30;
    localparam int CSM_REG_BITS = 8;

    // Reset values
    localparam logic [7:0] CSM_RST_PORT_CFG = 8'h18;
    localparam logic [7:0] CSM_RST_OUT_FMT = 8'h01;
    localparam logic [7:0] CSM_RST_CLOCK = 8'h01;
    localparam logic [7:0] CSM_RST_FUNC = 8'h00;
    localparam logic [7:0] CSM_RST_DATA = 8'h00;

    // Field positions
    localparam int CSM_CFG_LSB_HI = 6;
    localparam int CSM_CFG_LSB_LO = 1;
    localparam int CSM_CFG_SRST_HI = 5;
    localparam int CSM_CFG_SRST_LO = 2;
    localparam int CSM_CFG_ONE_HI = 4;
    localparam int CSM_CFG_ONE_LO = 3;
    localparam int CSM_COMMIT_BIT = 0;

    // Instruction layout
    localparam int CSM_INSTR_BITS = 16;
    localparam int CSM_INSTR_RW = 15;
    localparam int CSM_INSTR_LEN_HI = 14;
    localparam int CSM_INSTR_LEN_LO = 13;
    localparam int CSM_ADDR_BITS = 13;
    localparam logic [1:0] CSM_LEN_STREAM = 2'b11;

    // Pins sampled into core_clk: {sclk, csb, sdio}; idle levels at reset
    localparam int CSM_PIN_COUNT = 3;
    localparam logic [2:0] CSM_PIN_IDLE = 3'h2;
    localparam int CSM_PIN_SCLK = 2;
    localparam int CSM_PIN_CSB = 1;
    localparam int CSM_PIN_SDIO = 0;

    typedef enum logic [1:0] {CSM_PH_IDLE, CSM_PH_INSTR, CSM_PH_DATA, CSM_PH_DONE} csm_phase_type;

    function automatic logic [7:0] csm_func_reset(input int idx);
        logic [7:0] addr;
        addr = CSM_ADDR_FUNC_FIRST + idx[7:0];
        if (addr == CSM_ADDR_OUT_FMT) begin
            return CSM_RST_OUT_FMT;
        end
        if (addr == CSM_ADDR_CLOCK) begin
            return CSM_RST_CLOCK;
        end
        return CSM_RST_FUNC;
    endfunction

endpackage

// file: verilog/csm_reg_bank.sv
// Shadow and active copies of the converter function registers.
// Assumes one write and one read request per cycle from the serial front end.
`timescale 1ns/1ps
`default_nettype none
module csm_reg_bank (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Write port
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port, data one cycle later
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // Commit of all shadowed entries
    input wire logic commit,
    output logic [csm_pkg::CSM_FUNC_COUNT*csm_pkg::CSM_REG_BITS-1:0] active_flat
);
    import csm_pkg::*;

    logic [7:0] shadow_q [CSM_FUNC_COUNT];
    logic [7:0] active_q [CSM_FUNC_COUNT];
    logic [7:0] rd_data_q;
    logic [7:0] rd_idx;

    assign rd_idx = rd_addr - CSM_ADDR_FUNC_FIRST;
    assign rd_data = rd_data_q;

    for (genvar i = 0; i < CSM_FUNC_COUNT; i++) begin : g_entry
        localparam logic [7:0] ADDR = CSM_ADDR_FUNC_FIRST + 8'(i);
        localparam bit SHADOWED = ADDR <= CSM_ADDR_SHADOW_LAST;
        localparam logic [7:0] RST = csm_func_reset(i);
        logic hit;
        assign hit = wr_en && (wr_addr == ADDR);

        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                shadow_q[i] <= RST;
            end else if (hit) begin
                shadow_q[i] <= wr_data;
            end
        end

        // Shadowed entries move only on commit, all in the same edge
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                active_q[i] <= RST;
            end else if (SHADOWED) begin
                if (commit) begin
                    active_q[i] <= shadow_q[i];
                end
            end else if (hit) begin
                active_q[i] <= wr_data;
            end
        end

        assign active_flat[i*CSM_REG_BITS +: CSM_REG_BITS] = active_q[i];

        if (SHADOWED) begin : g_check
            a_shadow_hold: assert property (@(posedge core_clk) disable iff (!resetn)
                !commit |=> $stable(active_q[i]))
                else $error("shadowed register changed without commit");
            a_commit_copy: assert property (@(posedge core_clk) disable iff (!resetn)
                commit |=> active_q[i] == $past(shadow_q[i]))
                else $error("commit did not copy shadow value");
        end
    end

    // Reads return the shadow copy so software sees what it last wrote
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_q <= CSM_RST_DATA;
        end else if (rd_en) begin
            if (rd_addr >= CSM_ADDR_FUNC_FIRST && rd_addr <= CSM_ADDR_FUNC_LAST) begin
                rd_data_q <= shadow_q[rd_idx[4:0]];
            end else begin
                rd_data_q <= CSM_RST_DATA;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb/csm_host_model.sv
// Serial host that frames 3-wire register accesses for the register map.
// Assumes core_clk is the only time base; sclk phases are 10 core_clk long.
`timescale 1ns/1ps
`default_nettype none
module csm_host_model (
    // Clock
    input wire logic core_clk,
    // Serial pins
    output logic sclk,
    output logic csb,
    output logic sdio_host,
    input wire logic sdio_out,
    input wire logic sdio_oe
);
    initial begin
        sclk = 1'b0;
        csb = 1'b1;
        sdio_host = 1'b0;
    end

    task automatic half();
        repeat (10) @(posedge core_clk);
    endtask

    // Callers only write assigned locations
    task automatic xfer(input logic lsb, input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic oe_any);
        logic [15:0] instr;
        logic [7:0] d;
        logic [23:0] fr;
        logic [7:0] got;
        // Single-byte length, upper address bits zero
        instr = {rd, 2'b00, 5'h00, addr};
        d = wdata;
        got = 8'h00;
        oe_any = 1'b0;
        if (lsb) begin
            instr = {<<{instr}};
            d = {<<{d}};
        end
        fr = {instr, d};
        @(posedge core_clk);
        csb <= 1'b0;
        half();
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b0;
            // Released line toggles so a stale level is never mistaken for data
            sdio_host <= (rd && i < 8) ? ~sdio_host : fr[i];
            half();
            if (i < 8) begin
                // An undriven line reads as the inverse, so a missing enable spoils the data
                got = {got[6:0], sdio_oe ? sdio_out : ~sdio_out};
                oe_any = oe_any | sdio_oe;
            end
            sclk <= 1'b1;
            half();
        end
        sclk <= 1'b0;
        half();
        csb <= 1'b1;
        sdio_host <= 1'b0;
        half();
        rdata = lsb ? {<<{got}} : got;
    endtask
endmodule
`default_nettype wire

// file: tb/csm_register_map_tb_top.sv
// Self-checking bench of the register map, driven through the serial host model.
// Assumes a 100 MHz core_clk and a bounded run under 40000 cycles.
`timescale 1ns/1ps
`default_nettype none
module csm_register_map_tb_top;
    import csm_pkg::*;
    localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
    logic core_clk;
    logic resetn;
    logic sclk;
    logic csb;
    logic sdio_host;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic lsb_first;
    logic soft_reset;
    logic [CSM_FUNC_COUNT*CSM_REG_BITS-1:0] func_active;
    int mismatches;
    int n_tests;
    int cycles;

    // Device wins the shared data line only while it drives it
    assign sdio_in = sdio_oe ? sdio_out : sdio_host;

    csm_register_map #(.IDENTITY_CODE(ID_CODE), .GRADE_CODE(8'h00)) DUT (
        .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .csb(csb), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .lsb_first(lsb_first), .soft_reset(soft_reset),
        .func_active(func_active)
    );

    csm_host_model host (
        .core_clk(core_clk), .sclk(sclk), .csb(csb), .sdio_host(sdio_host),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            results();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] fa(input int a);
        return func_active[8*(a-8) +: 8];
    endfunction

    task automatic rd(input logic lsb, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic oe;
        host.xfer(lsb, 1'b1, a, 8'h00, v, oe);
        chk("read sdio_oe", 8'h01, {7'h00, oe});
        chk("read data", exp, v);
    endtask

    task automatic wr(input logic lsb, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        logic oe;
        host.xfer(lsb, 1'b0, a, d, v, oe);
        chk("write sdio_oe", 8'h00, {7'h00, oe});
    endtask

    task automatic t_reset();
        for (int a = 8; a <= 37; a++) begin
            chk("func_active default", (a == 9 || a == 20) ? 8'h01 : 8'h00, fa(a));
        end
        chk("output format default", 8'h01, fa(20));
        chk("lsb_first", 8'h00, {7'h00, lsb_first});
        chk("soft_reset", 8'h00, {7'h00, soft_reset});
        $display("test reset done");
    endtask

    task automatic t_identity();
        rd(1'b0, 8'h00, 8'h18);
        rd(1'b0, 8'h01, ID_CODE);
        wr(1'b0, 8'h01, 8'hc3);
        rd(1'b0, 8'h01, ID_CODE);
        rd(1'b0, 8'h02, 8'h00);
        rd(1'b0, 8'h03, 8'h00);
        rd(1'b0, 8'h26, 8'h00);
        $display("test identity done");
    endtask

    task automatic t_shadow();
        wr(1'b0, 8'h08, 8'h02);
        wr(1'b0, 8'h14, 8'h00);
        wr(1'b0, 8'h20, 8'h7f);
        wr(1'b0, 8'h21, 8'h55);
        wr(1'b0, 8'h25, 8'ha5);
        chk("0x08 before commit", 8'h00, fa(8));
        chk("0x14 before commit", 8'h01, fa(20));
        chk("0x20 before commit", 8'h00, fa(32));
        chk("0x21 direct", 8'h55, fa(33));
        chk("0x25 direct", 8'ha5, fa(37));
        rd(1'b0, 8'h14, 8'h00);
        wr(1'b0, 8'hff, 8'h01);
        chk("0x08 after commit", 8'h02, fa(8));
        chk("0x14 after commit", 8'h00, fa(20));
        chk("0x20 after commit", 8'h7f, fa(32));
        chk("0x09 untouched", 8'h01, fa(9));
        rd(1'b0, 8'hff, 8'h00);
        $display("test shadow done");
    endtask

    task automatic t_port_cfg();
        // Only the upper soft-reset copy is set; the read must show both
        wr(1'b0, 8'h00, 8'h38);
        chk("soft_reset set", 8'h01, {7'h00, soft_reset});
        rd(1'b0, 8'h00, 8'h3c);
        wr(1'b0, 8'h00, 8'h58);
        chk("lsb_first set", 8'h01, {7'h00, lsb_first});
        rd(1'b1, 8'h00, 8'h5a);
        wr(1'b1, 8'h00, 8'h18);
        chk("lsb_first clear", 8'h00, {7'h00, lsb_first});
        rd(1'b0, 8'h00, 8'h18);
        $display("test port config done");
    endtask

    // Reset in mid-run must bring back every default after registers were changed
    task automatic t_midrun_reset();
        wr(1'b0, 8'h00, 8'h3c);
        chk("soft_reset before reset", 8'h01, {7'h00, soft_reset});
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_reset();
        rd(1'b0, 8'h14, 8'h01);
        rd(1'b0, 8'h00, 8'h18);
        $display("test midrun reset done");
    endtask

    initial begin
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_reset();
        t_identity();
        t_shadow();
        t_port_cfg();
        t_midrun_reset();
        results();
    end
endmodule
`default_nettype wire
